/* File: evp_consts.svh */
`ifndef EVP_CONSTS_SVH
`define EVP_CONSTS_SVH

// register byte offsets on the avalon word bus
`define EVP_OFS_EDGE        8'h00
`define EVP_OFS_PEND        8'h04
`define EVP_OFS_VEC         8'h08

// edge-select register layout
`define EVP_EDGE_NMI_BIT    7
`define EVP_EDGE_RSV        8'h70
`define EVP_EDGE_RST        8'h70
`define EVP_EDGE_PIN_MSB    3

// source indices, highest priority first
`define EVP_SRC_RST         0
`define EVP_SRC_NMI         1
`define EVP_SRC_TRAP0       2
`define EVP_SRC_BRK         6
`define EVP_SRC_SLP         7
`define EVP_SRC_PIN0        8
`define EVP_SRC_WKP         12
`define EVP_SRC_RTC         13
`define EVP_SRC_TMV         14
`define EVP_SRC_SER0        15
`define EVP_SRC_TWB         16
`define EVP_SRC_ADC         17
`define EVP_SRC_TZ0         18
`define EVP_SRC_TZ1         19
`define EVP_SRC_TB1         20
`define EVP_SRC_SER1        21
`define EVP_NSRC            22

// sources that ignore the processor mask bit
`define EVP_NOMASK          22'h00007f
`define EVP_PEND_RST        22'h000001

// vector numbers of the table
`define EVP_VEC_RST         6'h00
`define EVP_VEC_NMI         6'h07
`define EVP_VEC_TRAP0       6'h08
`define EVP_VEC_BRK         6'h0c
`define EVP_VEC_SLP         6'h0d
`define EVP_VEC_PIN0        6'h0e
`define EVP_VEC_WKP         6'h12
`define EVP_VEC_RTC         6'h13
`define EVP_VEC_TMV         6'h16
`define EVP_VEC_SER0        6'h17
`define EVP_VEC_TWB         6'h18
`define EVP_VEC_ADC         6'h19
`define EVP_VEC_TZ0         6'h1a
`define EVP_VEC_TZ1         6'h1b
`define EVP_VEC_TB1         6'h1d
`define EVP_VEC_SER1        6'h20

`endif

/* File: evp_pkg.sv */
package evp_pkg;

	// peripheral event pulses, grouped per module
	typedef struct packed {
		logic [2:0] timerV;
		logic [3:0] serial0;
		logic [5:0] twoWire;
		logic       adcEnd;
		logic [4:0] tmrZ0;
		logic [5:0] tmrZ1;
		logic       timerB1Ovf;
		logic [3:0] serial1;
	} evp_periph_s;

	// exception presented to the core
	typedef struct packed {
		logic        req;
		logic [5:0]  vecNum;
		logic [15:0] vecAddr;
	} evp_exc_s;

	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_ANSWER
	} evp_bus_e;

	typedef logic [21:0] evp_src_t;

endpackage

/* File: evp_edge_detect.sv */
`timescale 1ns/1ps

module evp_edge_detect (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// pin and edge choice
	input  wire logic pinIn,
	input  wire logic riseSel,
	// single-cycle request
	output logic      edgePulse
);

	logic syncA_r;
	logic syncB_r;
	logic last_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			syncA_r <= 1'b1;
			syncB_r <= 1'b1;
			last_r  <= 1'b1;
		end else begin
			syncA_r <= pinIn;
			syncB_r <= syncA_r;
			last_r  <= syncB_r;
		end
	end

	// edge direction chosen
	// sync starts high so an idle-low pin at reset looks like a falling edge
	// only when falling is selected; software should pick the edge first
	always_comb begin
		if (riseSel)
			edgePulse = syncB_r & ~last_r;
		else
			edgePulse = ~syncB_r & last_r;
	end

endmodule

/* File: evp_exception_ctrl.sv */
`timescale 1ns/1ps
`include "evp_consts.svh"

// Functional notes
// - simultaneous requests are presented highest fixed priority first.
// - each source has a vector; entry address is twice it; reset is 0.
// - vectors 1 to 6 and 20 are never produced.
// - sleep-instruction direct transition raises vector 13 at 0x001a.
// - timer V compare A, compare B and overflow share vector 22.
// - serial channel causes share vector 23; second channel uses 32.
// - all six two-wire bus causes share vector 24.
// - multi-timer channel 0 uses vector 26, channel 1 uses 27.
// - low-voltage interrupt shares vector 14, only when that circuit exists.
// - nmi and four pin interrupts fire on the selected edge.
// - edge-select bit 7 picks nmi edge; 0 falling after reset.
// - edge-select bits 3..0 pick pin edges; 0 falling after reset.
// - edge-select bits 6..4 always read as one.
// - trap operand 0 to 3 selects vectors 8 to 11.
// - mask bit set blocks all interrupts but nmi and address break.
module evp_exception_ctrl #(
	parameter bit HAS_LVD = 1'b1
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	// avalon-mm slave
	input  wire logic [7:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic [31:0]              readdata,
	output logic                     waitrequest,
	// external interrupt pins
	input  wire logic                nmiPin,
	input  wire logic [3:0]          ext_pin_int,
	// cpu events, same clock
	input  wire logic                trap_instruction,
	input  wire logic [1:0]          trapOperand,
	input  wire logic                breakMatch,
	input  wire logic                sleepDirect,
	input  wire logic                condition_code_reg_i,
	// other event sources, same clock
	input  wire logic                lowVoltInt,
	input  wire logic                wakeup_pins,
	input  wire logic                rtcOvf,
	input  wire evp_pkg::evp_periph_s periph,
	// exception handshake with the core
	output evp_pkg::evp_exc_s        exc,
	input  wire logic                excAck
);

	////////////////////////////////////////////////////////////////////////
	// parameter check

	// the constants header and the package must agree on the source count,
	// and the software clear only spans three byte lanes
	generate
		if (HAS_LVD !== 1'b0 && HAS_LVD !== 1'b1) begin : gBadLvd
			$error("HAS_LVD must be 0 or 1");
		end
		if (`EVP_NSRC != $bits(evp_pkg::evp_src_t)) begin : gBadNsrc
			$error("source count and pending width differ");
		end
		if (`EVP_NSRC > 24) begin : gBadLanes
			$error("pending word wider than three byte lanes");
		end
		if (`EVP_EDGE_PIN_MSB != 3) begin : gBadPins
			$error("edge detectors serve exactly four numbered pins");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [7:0]       edgeSel_r;
	evp_pkg::evp_src_t pend_r;
	evp_pkg::evp_src_t pendSet;
	evp_pkg::evp_src_t pendClr;
	evp_pkg::evp_src_t eligible;
	evp_pkg::evp_bus_e busState_r;
	logic [31:0]      readdata_r;
	logic [4:0]       pinPulse;
	logic [4:0]       pinIn;
	logic [4:0]       pinRise;
	logic [4:0]       curIdx_r;
	logic [4:0]       winIdx;
	logic             winAny;
	evp_pkg::evp_exc_s exc_r;
	logic             busReq;
	logic             busDone;
	logic             wrEdge;
	logic             wrPend;
	logic [23:0]      laneClr;
	logic [31:0]      vecStatus;
	logic [31:0]      readMux;

	////////////////////////////////////////////////////////////////////////
	// source index to vector number

	// the table holds no entry for the reserved numbers 1 to 6, 20, 21, 28,
	// 30 and 31, so no index can ever produce them; an out-of-range index
	// falls back to the reset vector, which is harmless because the
	// priority encoder never yields one
	// fixed vector per source
	function automatic logic [5:0] vecOf(input logic [4:0] idx);
		logic [5:0] v;
		v = `EVP_VEC_RST;
		case (idx)
			5'h00: v = `EVP_VEC_RST;
			5'h01: v = `EVP_VEC_NMI;
			5'h02: v = `EVP_VEC_TRAP0;
			5'h03: v = `EVP_VEC_TRAP0 + 6'h01;
			5'h04: v = `EVP_VEC_TRAP0 + 6'h02;
			5'h05: v = `EVP_VEC_TRAP0 + 6'h03;
			5'h06: v = `EVP_VEC_BRK;
			5'h07: v = `EVP_VEC_SLP;
			5'h08: v = `EVP_VEC_PIN0;
			5'h09: v = `EVP_VEC_PIN0 + 6'h01;
			5'h0a: v = `EVP_VEC_PIN0 + 6'h02;
			5'h0b: v = `EVP_VEC_PIN0 + 6'h03;
			5'h0c: v = `EVP_VEC_WKP;
			5'h0d: v = `EVP_VEC_RTC;
			5'h0e: v = `EVP_VEC_TMV;
			5'h0f: v = `EVP_VEC_SER0;
			5'h10: v = `EVP_VEC_TWB;
			5'h11: v = `EVP_VEC_ADC;
			5'h12: v = `EVP_VEC_TZ0;
			5'h13: v = `EVP_VEC_TZ1;
			5'h14: v = `EVP_VEC_TB1;
			5'h15: v = `EVP_VEC_SER1;
			default: v = `EVP_VEC_RST;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin edge detectors

	// bit 0 of the detector row is the nmi pin, bits 1..4 the numbered pins;
	// a pin change reaches pending three edges later through the synchroniser
	assign pinIn   = {ext_pin_int, nmiPin};
	assign pinRise = {edgeSel_r[`EVP_EDGE_PIN_MSB:0], edgeSel_r[`EVP_EDGE_NMI_BIT]};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : gPin
			evp_edge_detect uEdge (
				.clk_sys   (clk_sys),
				.sys_rst   (sys_rst),
				.pinIn     (pinIn[gi]),
				.riseSel   (pinRise[gi]),
				.edgePulse (pinPulse[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// event collection

	// pending bit map, also the software view of the pending register:
	// 0 reset, 1 nmi, 2..5 trap 0..3, 6 break, 7 sleep transition,
	// 8..11 numbered pins 0..3, 12 wakeup, 13 clock overflow, 14 timer v,
	// 15 first serial channel, 16 two-wire bus, 17 converter end,
	// 18 and 19 multi-timer channels, 20 timer b1, 21 second serial channel

	// shared vectors merge their causes by or-reduction; the handler reads
	// the cause itself from the peripheral
	always_comb begin
		pendSet = '0;
		pendSet[`EVP_SRC_NMI] = pinPulse[0];
		if (trap_instruction)
			pendSet[`EVP_SRC_TRAP0 + trapOperand] = 1'b1;
		pendSet[`EVP_SRC_BRK] = breakMatch;
		pendSet[`EVP_SRC_SLP] = sleepDirect;
		pendSet[`EVP_SRC_PIN0] = pinPulse[1] | (HAS_LVD & lowVoltInt);
		pendSet[`EVP_SRC_PIN0 + 1] = pinPulse[2];
		pendSet[`EVP_SRC_PIN0 + 2] = pinPulse[3];
		pendSet[`EVP_SRC_PIN0 + 3] = pinPulse[4];
		pendSet[`EVP_SRC_WKP] = wakeup_pins;
		pendSet[`EVP_SRC_RTC] = rtcOvf;
		pendSet[`EVP_SRC_TMV] = |periph.timerV;
		pendSet[`EVP_SRC_SER0] = |periph.serial0;
		pendSet[`EVP_SRC_SER1] = |periph.serial1;
		pendSet[`EVP_SRC_TWB] = |periph.twoWire;
		pendSet[`EVP_SRC_ADC] = periph.adcEnd;
		pendSet[`EVP_SRC_TZ0] = |periph.tmrZ0;
		pendSet[`EVP_SRC_TZ1] = |periph.tmrZ1;
		pendSet[`EVP_SRC_TB1] = periph.timerB1Ovf;
	end

	////////////////////////////////////////////////////////////////////////
	// pending flags

	// software clears every enabled byte lane in one write; only bits of real sources survive
	genvar gl;
	generate
		for (gl = 0; gl < 3; gl++) begin : gLane
			assign laneClr[gl*8 +: 8] = (wrPend && byteenable[gl]) ? writedata[gl*8 +: 8] : 8'h00;
		end
	endgenerate

	// the core's acknowledge clears the bit of the vector it took; a write-1
	// and an acknowledge in one cycle simply merge
	always_comb begin
		pendClr = laneClr[`EVP_NSRC-1:0];
		if (excAck && exc_r.req)
			pendClr[curIdx_r] = 1'b1;
	end

	// reset request stands pending after reset; a set beats a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			pend_r <= `EVP_PEND_RST;
		else
			pend_r <= (pend_r & ~pendClr) | pendSet;
	end

	////////////////////////////////////////////////////////////////////////
	// priority selection

	// the mask bit is read in the same cycle as the pending word, so a
	// source masked at this edge cannot slip through one cycle late; trap,
	// break, nmi and reset sit in the low bits that the mask never touches,
	// and the sleep transition is masked like any other internal source
	// mask bit gates maskable sources
	assign eligible = condition_code_reg_i ? (pend_r & `EVP_NOMASK) : pend_r;

	// scanning from the top down lets the lowest pending index overwrite
	// every other candidate, which is the fixed priority order
	// lowest index wins
	always_comb begin
		winIdx = 5'h00;
		winAny = 1'b0;
		for (int i = `EVP_NSRC - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				winIdx = 5'(i);
				winAny = 1'b1;
			end
		end
	end

	// limitation: a source that pends during the acknowledge cycle waits one
	// extra cycle, since the request drops there to let the core see the
	// change; the reset vector stands until the core takes it
	// the request is re-evaluated each cycle but frozen in the ack cycle
	// so the cleared bit always matches the vector the core took
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			exc_r    <= '0;
			curIdx_r <= 5'h00;
		end else if (excAck && exc_r.req) begin
			exc_r.req <= 1'b0;
		end else begin
			exc_r.req    <= winAny;
			exc_r.vecNum <= vecOf(winIdx);
			exc_r.vecAddr <= {9'h000, vecOf(winIdx), 1'b0};
			curIdx_r     <= winIdx;
		end
	end

	assign exc = exc_r;

	////////////////////////////////////////////////////////////////////////
	// avalon-mm slave

	// the slave never stalls longer than one cycle, so no timeout is needed;
	// a write lands at the edge where the master sees waitrequest low
	// one wait cycle: the answer is loaded, then waitrequest drops
	assign busReq      = read | write;
	assign busDone     = busReq && (busState_r == evp_pkg::BUS_ANSWER);
	assign waitrequest = busReq && (busState_r != evp_pkg::BUS_ANSWER);
	assign wrEdge      = busDone && write && (address == `EVP_OFS_EDGE);
	assign wrPend      = busDone && write && (address == `EVP_OFS_PEND);

	// two-state answer sequencer: idle until a strobe appears, then one
	// answer cycle in which waitrequest is low and the transfer completes;
	// back-to-back requests each pay the one wait cycle again
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busState_r <= evp_pkg::BUS_IDLE;
		end else begin
			case (busState_r)
				evp_pkg::BUS_IDLE: begin
					if (busReq)
						busState_r <= evp_pkg::BUS_ANSWER;
				end
				evp_pkg::BUS_ANSWER: begin
					busState_r <= evp_pkg::BUS_IDLE;
				end
				default: busState_r <= evp_pkg::BUS_IDLE;
			endcase
		end
	end

	// reserved bits are forced high on write as well as on read, so the
	// stored byte always matches what software reads back
	// pin edge bits writable
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			edgeSel_r <= `EVP_EDGE_RST;
		else if (wrEdge && byteenable[0])
			edgeSel_r <= writedata[7:0] | `EVP_EDGE_RSV;
	end

	// vector status word: request flag, entry address, vector number
	assign vecStatus = {9'h000, exc_r.req, exc_r.vecAddr, exc_r.vecNum};

	// read decode; unmapped addresses read zero
	always_comb begin
		readMux = 32'h0000_0000;
		case (address)
			`EVP_OFS_EDGE: readMux = {24'h000000, edgeSel_r | `EVP_EDGE_RSV};
			`EVP_OFS_PEND: readMux = {10'h000, pend_r};
			`EVP_OFS_VEC:  readMux = vecStatus;
			default:       readMux = 32'h0000_0000;
		endcase
	end

	// read data loads in the wait cycle and then stands until the next read,
	// so a slow master still sees the value it asked for
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			readdata_r <= 32'h0000_0000;
		else if (read && busState_r == evp_pkg::BUS_IDLE)
			readdata_r <= readMux;
	end

	assign readdata = readdata_r;

endmodule

/* File: evp_exception_ctrl_checker.sv */
`timescale 1ns/1ps
module evp_exception_ctrl_checker (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	// register bus
	input wire logic              read,
	input wire logic              write,
	input wire logic              waitrequest,
	// core side
	input wire logic              trap_instruction,
	input wire logic [1:0]        trapOperand,
	input wire logic              condition_code_reg_i,
	input wire evp_pkg::evp_exc_s exc,
	input wire logic              excAck
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	////////////////////////////////
	// a trap with no ack in the way, so only a higher-priority source can hide its vector
	sequence trapClean;
		(trap_instruction && !excAck) ##1 !excAck;
	endsequence
	a_addr_twice: assert property (exc.req |-> exc.vecAddr == {9'h000, exc.vecNum, 1'b0})
		else $error("vector address is not twice the vector number");
	a_no_reserved: assert property (exc.req |-> exc.vecNum <= 6'h20 &&
		!(exc.vecNum inside {[6'h01:6'h06], 6'h14, 6'h15, 6'h1c, [6'h1e:6'h1f]}))
		else $error("reserved vector number presented");
	a_trap_vector: assert property (trapClean |-> ##1
		exc.req && exc.vecNum <= {4'h2, $past(trapOperand, 2)})
		else $error("trap vector missing or wrong");
	a_mask_holds: assert property (exc.req && exc.vecNum >= 6'h0d && !$past(excAck)
		|-> !$past(condition_code_reg_i))
		else $error("maskable vector presented while masked");
	a_ack_drops: assert property (excAck |=> !exc.req)
		else $error("request stayed up after acknowledge");
	a_rst_clears: assert property (disable iff (1'b0) sys_rst |=> !exc.req)
		else $error("request up during reset");
	a_rst_vector: assert property ($fell(sys_rst) |-> ##[1:2] exc.req && exc.vecNum == 6'h00)
		else $error("reset vector not presented after reset");
	a_wait_first: assert property ($rose(read || write) |-> waitrequest)
		else $error("request answered without a wait cycle");
	a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("more than one wait cycle");
endmodule
bind evp_exception_ctrl evp_exception_ctrl_checker i_chk (.clk_sys, .sys_rst, .read, .write,
	.waitrequest, .trap_instruction, .trapOperand, .condition_code_reg_i, .exc, .excAck);

/* File: evp_core_model.sv */
`timescale 1ns/1ps
module evp_core_model (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	// presented exception and pacing
	input  wire evp_pkg::evp_exc_s exc,
	input  wire logic              ackEn,
	input  wire logic [1:0]        ackDelay,
	// take of the presented vector
	output logic                   excAck
);
	logic [1:0] waitCnt_r;
	// a slow core lets the vector stand; no ack in the cycle after an ack,
	// since the request is dropped there
	always_ff @(posedge clk_sys) begin
		excAck <= 1'b0;
		if (sys_rst || !exc.req || excAck || !ackEn) begin
			waitCnt_r <= 2'h0;
		end else if (waitCnt_r == ackDelay) begin
			excAck <= 1'b1;
		end else begin
			waitCnt_r <= waitCnt_r + 2'h1;
		end
	end
endmodule

/* File: test_exception_vector_priority_edge_select.sv */
`timescale 1ns/1ps
`include "evp_consts.svh"
module test_exception_vector_priority_edge_select;
	logic clk_sys, sys_rst, read, write, waitrequest, excAck, ackEn;
	logic [7:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable, ext_pin_int;
	logic [1:0] ackDelay, trapOperand;
	logic [4:0] pins;
	logic [38:0] ev;
	logic nmiPin, trap_instruction, breakMatch, sleepDirect, lowVoltInt, wakeup_pins, rtcOvf;
	logic condition_code_reg_i;
	evp_pkg::evp_periph_s periph;
	evp_pkg::evp_exc_s exc;
	int errTotal, samplesChecked, cyc;
	logic [5:0] seen [$];
	// rows: first event bit, vector it must give
	logic [11:0] rows [18] = '{12'h00c, 12'h04d, 12'h08e, 12'h0d2, 12'h113, 12'h160,
		12'h25d, 12'h29b, 12'h41a, 12'h559, 12'h598, 12'h717, 12'h816, 12'h8c8,
		12'h909, 12'h94a, 12'h98b, 12'h9c0};
	// event bits fan out to the source inputs
	assign {periph, rtcOvf, wakeup_pins, lowVoltInt, sleepDirect, breakMatch} = ev[34:0];
	assign trap_instruction = |ev[38:35];
	assign trapOperand = {ev[37] | ev[38], ev[36] | ev[38]};
	assign {nmiPin, ext_pin_int} = pins;
	evp_exception_ctrl i_dut (.clk_sys, .sys_rst, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .nmiPin, .ext_pin_int, .trap_instruction,
		.trapOperand, .breakMatch, .sleepDirect, .condition_code_reg_i, .lowVoltInt,
		.wakeup_pins, .rtcOvf, .periph, .exc, .excAck);
	evp_core_model i_core (.clk_sys, .sys_rst, .exc, .ackEn, .ackDelay, .excAck);
	////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// record each vector as the core takes it
	always @(negedge clk_sys) begin
		if (excAck === 1'b1)
			seen.push_back(exc.vecNum);
	end
	// hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errTotal++;
			results();
		end
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samplesChecked++;
		if (g !== e) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	// one avalon cycle: hold until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task fire(input logic [38:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= '0;
	endtask
	task takeVec(input logic [5:0] v);
		int n;
		n = 0;
		while (seen.size() == 0 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		chk("vector", {26'h0, v}, (seen.size() > 0) ? {26'h0, seen.pop_front()} : 32'hffff);
	endtask
	task quiet;
		repeat (10) @(negedge clk_sys);
		chk("no request", 32'h0, seen.size());
	endtask
	task results;
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		{sys_rst, read, write, address, writedata, byteenable} = {3'h4, 8'h00, 32'h0, 4'hf};
		{pins, ev, condition_code_reg_i, ackEn, ackDelay} = {5'h1f, 39'h0, 4'h4};
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		takeVec(6'h00);
		bus(1'b0, `EVP_OFS_EDGE, 32'h0);
		chk("edge select reset", 32'h70, q);
		bus(1'b0, 8'h0c, 32'h0);
		chk("unmapped read", 32'h0, q);
		$display("reset test done");
		// every event bit, core pacing varied
		for (int r = 0; r < 17; r++) begin
			for (int k = rows[r][11:6]; k < rows[r + 1][11:6]; k++) begin
				ackDelay <= k[1:0];
				fire(39'h1 << k);
				takeVec(rows[r][5:0]);
			end
		end
		$display("source table test done");
		// masked sources wait while the trap goes through at once
		@(posedge clk_sys);
		condition_code_reg_i <= 1'b1;
		fire(39'h4000010030);
		takeVec(6'h0b);
		quiet();
		@(posedge clk_sys);
		condition_code_reg_i <= 1'b0;
		takeVec(6'h13);
		takeVec(6'h1a);
		takeVec(6'h20);
		$display("mask and priority test done");
		// software view: status word, pending word and write-1 clear
		@(posedge clk_sys);
		ackEn <= 1'b0;
		fire(39'h10);
		repeat (4) @(posedge clk_sys);
		bus(1'b0, `EVP_OFS_VEC, 32'h0);
		chk("vector status", 32'h0040_0993, q);
		bus(1'b0, `EVP_OFS_PEND, 32'h0);
		chk("pending word", 32'h0000_2000, q);
		bus(1'b1, `EVP_OFS_PEND, 32'h0000_2000);
		bus(1'b0, `EVP_OFS_PEND, 32'h0);
		chk("pending cleared", 32'h0, q);
		ackEn <= 1'b1;
		quiet();
		$display("register test done");
		// falling edges first, then rising after selecting them
		for (int m = 0; m < 2; m++) begin
			if (m == 1)
				bus(1'b1, `EVP_OFS_EDGE, 32'h8f);
			for (int p = 0; p < 5; p++) begin
				for (int l = 0; l < 2; l++) begin
					@(posedge clk_sys);
					pins[p] <= l[0];
					if (l == m)
						takeVec((p < 4) ? 6'h0e + p[5:0] : 6'h07);
					else
						quiet();
				end
			end
		end
		bus(1'b0, `EVP_OFS_EDGE, 32'h0);
		chk("edge select all set", 32'hff, q);
		bus(1'b1, `EVP_OFS_EDGE, 32'h0);
		bus(1'b0, `EVP_OFS_EDGE, 32'h0);
		chk("edge select cleared", 32'h70, q);
		$display("edge select test done");
		results();
	end
endmodule
